// *** logic/trcfg_mode_dec.sv ***
`default_nettype none
module trcfg_mode_dec (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic [2:0]             i_code,
    output trcfg_pkg::trcfg_mode_t      o_mode,
    output logic                        o_reserved
);
    // Reserved codes keep the last legal mode so the radio never sees an undefined state
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mode     <= trcfg_pkg::MODE_STANDBY;
            o_reserved <= 1'b0;
        end else begin
            o_reserved <= 1'b0;
            case (i_code)
                trcfg_pkg::CODE_SLEEP:   o_mode <= trcfg_pkg::MODE_SLEEP;
                trcfg_pkg::CODE_STANDBY: o_mode <= trcfg_pkg::MODE_STANDBY;
                trcfg_pkg::CODE_SYNTH:   o_mode <= trcfg_pkg::MODE_SYNTH;
                trcfg_pkg::CODE_RX:      o_mode <= trcfg_pkg::MODE_RX;
                trcfg_pkg::CODE_TX:      o_mode <= trcfg_pkg::MODE_TX;
                default:                 o_reserved <= 1'b1;
            endcase
        end
    end
endmodule // trcfg_mode_dec

// *** logic/trcfg_pkg.sv ***
`default_nettype none
package trcfg_pkg;
    localparam logic [7:0] ADDR_GEN_CFG  = 8'h00;
    localparam logic [7:0] ADDR_RSSI     = 8'h14;
    localparam logic [7:0] ADDR_OOK      = 8'h15;
    localparam logic [7:0] ADDR_SYNC0    = 8'h16;
    localparam logic [7:0] ADDR_SYNC1    = 8'h17;
    localparam logic [7:0] ADDR_SYNC2    = 8'h18;
    localparam logic [7:0] ADDR_SYNC3    = 8'h19;
    localparam logic [7:0] ADDR_TX_CFG   = 8'h1A;
    localparam logic [7:0] ADDR_PAYLOAD  = 8'h1C;
    localparam logic [7:0] ADDR_NODE     = 8'h1D;
    localparam logic [7:0] ADDR_PKT_CFG  = 8'h1E;
    localparam logic [7:0] ADDR_FIFO_CRC = 8'h1F;
    localparam logic [7:0] RST_GEN_CFG   = 8'h28;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam int         MODE_LSB      = 5;
    localparam int         BAND_LSB      = 3;
    localparam int         VCO_LSB       = 1;
    localparam int         PLL_SEL_BIT   = 0;
    localparam int         CRC_OK_BIT    = 0;
    localparam logic [7:0] PKT_WR_MASK   = 8'hFE;
    typedef enum logic [4:0] {
        MODE_SLEEP   = 5'h01,
        MODE_STANDBY = 5'h02,
        MODE_SYNTH   = 5'h04,
        MODE_RX      = 5'h08,
        MODE_TX      = 5'h10
    } trcfg_mode_t;
    localparam logic [2:0] CODE_SLEEP   = 3'h0;
    localparam logic [2:0] CODE_STANDBY = 3'h1;
    localparam logic [2:0] CODE_SYNTH   = 3'h2;
    localparam logic [2:0] CODE_RX      = 3'h3;
    localparam logic [2:0] CODE_TX      = 3'h4;
endpackage
`default_nettype wire

// *** logic/trcfg_reg8.sv ***
`default_nettype none
module trcfg_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hFF
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_q
);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_q <= RESET_VAL;
        end else if (i_we) begin
            o_q <= (i_wdata & WR_MASK) | (o_q & ~WR_MASK);
        end
    end
endmodule // trcfg_reg8

// *** logic/trcfg_top.sv ***
`default_nettype none
module trcfg_top (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RESET_N,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [31:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [3:0]  I_PSTRB,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic [7:0]  I_RSSI,
    input  wire logic        I_CRC_OK,
    output logic      [4:0]  O_CHIP_MODE,
    output logic             O_MODE_RESERVED,
    output logic      [1:0]  O_BAND_SELECT,
    output logic      [1:0]  O_VCO_TUNE_TRIM,
    output logic             O_PLL_DIVIDER_SET_SELECT,
    output logic      [31:0] O_SYNC_WORD,
    output logic      [7:0]  O_OOK_CFG,
    output logic      [7:0]  O_TX_CFG,
    output logic      [7:0]  O_PAYLOAD_CFG,
    output logic      [7:0]  O_NODE_ADDR,
    output logic      [7:0]  O_PKT_CFG,
    output logic      [7:0]  O_FIFO_CRC_CFG
);
    logic        setup;
    logic        access;
    logic        wr;
    logic        hit;
    logic [7:0]  idx;
    logic [7:0]  gen_q;
    logic [7:0]  ook_q;
    logic [7:0]  sync_q [4];
    logic [7:0]  tx_q;
    logic [7:0]  pay_q;
    logic [7:0]  node_q;
    logic [7:0]  pkt_q;
    logic [7:0]  fcrc_q;
    logic [7:0]  rssi_r;
    logic        crc_ok_r;
    logic [7:0]  rd_nxt;
    logic [6:0]  we;
    logic [3:0]  we_sync;
    logic        answer;
    logic        rd_take;
    logic [7:0]  pkt_view;
    logic [31:0] sync_word;
    trcfg_pkg::trcfg_mode_t mode;
    logic        mode_rsv;

    // Printed offsets are not word aligned, so each is an index times four
    assign idx    = I_PADDR[9:2];
    assign setup  = I_PSEL && !I_PENABLE;
    assign access = I_PSEL && I_PENABLE;
    // One wait state: answer comes in the cycle after the access phase opens
    assign wr     = access && O_PREADY && I_PWRITE && I_PSTRB[0];

    // Single access cycle that arms ready and the error flag
    assign answer    = access && !O_PREADY;
    assign rd_take   = answer && !I_PWRITE && hit;
    // Bit 0 of the packet byte is the live CRC status, never the stored bit
    assign pkt_view  = {pkt_q[7:1], crc_ok_r};
    // Lowest address is the first byte on air, so it lands in the top byte
    assign sync_word = {sync_q[0], sync_q[1], sync_q[2], sync_q[3]};

    always_comb begin
        hit    = 1'b1;
        rd_nxt = 8'h00;
        case (idx)
            trcfg_pkg::ADDR_GEN_CFG:  rd_nxt = gen_q;
            trcfg_pkg::ADDR_RSSI:     rd_nxt = rssi_r;
            trcfg_pkg::ADDR_OOK:      rd_nxt = ook_q;
            trcfg_pkg::ADDR_SYNC0:    rd_nxt = sync_q[0];
            trcfg_pkg::ADDR_SYNC1:    rd_nxt = sync_q[1];
            trcfg_pkg::ADDR_SYNC2:    rd_nxt = sync_q[2];
            trcfg_pkg::ADDR_SYNC3:    rd_nxt = sync_q[3];
            trcfg_pkg::ADDR_TX_CFG:   rd_nxt = tx_q;
            trcfg_pkg::ADDR_PAYLOAD:  rd_nxt = pay_q;
            trcfg_pkg::ADDR_NODE:     rd_nxt = node_q;
            trcfg_pkg::ADDR_PKT_CFG:  rd_nxt = pkt_view;
            trcfg_pkg::ADDR_FIFO_CRC: rd_nxt = fcrc_q;
            default:                  hit = 1'b0;
        endcase
        if (I_PADDR[31:10] != 22'h0) begin
            hit = 1'b0;
        end
    end

    always_comb begin
        we = 7'h00;
        we_sync = 4'h0;
        if (wr && hit) begin
            case (idx)
                trcfg_pkg::ADDR_GEN_CFG:  we[0] = 1'b1;
                trcfg_pkg::ADDR_OOK:      we[1] = 1'b1;
                trcfg_pkg::ADDR_TX_CFG:   we[2] = 1'b1;
                trcfg_pkg::ADDR_PAYLOAD:  we[3] = 1'b1;
                trcfg_pkg::ADDR_NODE:     we[4] = 1'b1;
                trcfg_pkg::ADDR_PKT_CFG:  we[5] = 1'b1;
                trcfg_pkg::ADDR_FIFO_CRC: we[6] = 1'b1;
                trcfg_pkg::ADDR_SYNC0:    we_sync[0] = 1'b1;
                trcfg_pkg::ADDR_SYNC1:    we_sync[1] = 1'b1;
                trcfg_pkg::ADDR_SYNC2:    we_sync[2] = 1'b1;
                trcfg_pkg::ADDR_SYNC3:    we_sync[3] = 1'b1;
                default:                  we = 7'h00;
            endcase
        end
    end

    trcfg_reg8 #(
        .RESET_VAL(trcfg_pkg::RST_GEN_CFG),
        .WR_MASK  (8'hFF)
    ) u_gen (
        .i_clk    (I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_we     (we[0]),
        .i_wdata  (I_PWDATA[7:0]),
        .o_q      (gen_q)
    );

    trcfg_reg8 #(
        .RESET_VAL(trcfg_pkg::RST_ZERO),
        .WR_MASK  (8'hFF)
    ) u_ook (
        .i_clk    (I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_we     (we[1]),
        .i_wdata  (I_PWDATA[7:0]),
        .o_q      (ook_q)
    );

    trcfg_reg8 #(
        .RESET_VAL(trcfg_pkg::RST_ZERO),
        .WR_MASK  (8'hFF)
    ) u_tx (
        .i_clk    (I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_we     (we[2]),
        .i_wdata  (I_PWDATA[7:0]),
        .o_q      (tx_q)
    );

    trcfg_reg8 #(
        .RESET_VAL(trcfg_pkg::RST_ZERO),
        .WR_MASK  (8'hFF)
    ) u_pay (
        .i_clk    (I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_we     (we[3]),
        .i_wdata  (I_PWDATA[7:0]),
        .o_q      (pay_q)
    );

    trcfg_reg8 #(
        .RESET_VAL(trcfg_pkg::RST_ZERO),
        .WR_MASK  (8'hFF)
    ) u_node (
        .i_clk    (I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_we     (we[4]),
        .i_wdata  (I_PWDATA[7:0]),
        .o_q      (node_q)
    );

    // Status bit 0 is owned by the receiver, so software writes skip it
    trcfg_reg8 #(
        .RESET_VAL(trcfg_pkg::RST_ZERO),
        .WR_MASK  (trcfg_pkg::PKT_WR_MASK)
    ) u_pkt (
        .i_clk    (I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_we     (we[5]),
        .i_wdata  (I_PWDATA[7:0]),
        .o_q      (pkt_q)
    );

    trcfg_reg8 #(
        .RESET_VAL(trcfg_pkg::RST_ZERO),
        .WR_MASK  (8'hFF)
    ) u_fcrc (
        .i_clk    (I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_we     (we[6]),
        .i_wdata  (I_PWDATA[7:0]),
        .o_q      (fcrc_q)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            trcfg_reg8 #(
                .RESET_VAL(trcfg_pkg::RST_ZERO),
                .WR_MASK  (8'hFF)
            ) u_sync (
                .i_clk    (I_CORE_CLK),
                .i_reset_n(I_RESET_N),
                .i_we     (we_sync[g]),
                .i_wdata  (I_PWDATA[7:0]),
                .o_q      (sync_q[g])
            );
        end
    endgenerate

    trcfg_mode_dec u_mode (
        .i_clk(I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_code(gen_q[trcfg_pkg::MODE_LSB +: 3]),
        .o_mode(mode),
        .o_reserved(mode_rsv)
    );

    // Receiver status registered on every clock so a read sees a stable byte
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rssi_r <= 8'h00;
        end else begin
            rssi_r <= I_RSSI;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            crc_ok_r <= 1'b0;
        end else begin
            crc_ok_r <= I_CRC_OK;
        end
    end

    // Ready is a one-cycle pulse; a held access is answered again every second cycle
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PREADY <= 1'b0;
        end else begin
            O_PREADY <= answer;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PSLVERR <= 1'b0;
        end else begin
            O_PSLVERR <= answer && !hit;
        end
    end

    // Read data stands until the next setup, which clears it so no stale byte lingers
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PRDATA <= 32'h0000_0000;
        end else if (rd_take) begin
            O_PRDATA <= {24'h00_0000, rd_nxt};
        end else if (setup) begin
            O_PRDATA <= 32'h0000_0000;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_CHIP_MODE     <= trcfg_pkg::MODE_STANDBY;
            O_MODE_RESERVED <= 1'b0;
        end else begin
            O_CHIP_MODE     <= mode;
            O_MODE_RESERVED <= mode_rsv;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_BAND_SELECT            <= 2'h0;
            O_VCO_TUNE_TRIM          <= 2'h0;
            O_PLL_DIVIDER_SET_SELECT <= 1'b0;
        end else begin
            O_BAND_SELECT            <= gen_q[trcfg_pkg::BAND_LSB +: 2];
            O_VCO_TUNE_TRIM          <= gen_q[trcfg_pkg::VCO_LSB +: 2];
            O_PLL_DIVIDER_SET_SELECT <= gen_q[trcfg_pkg::PLL_SEL_BIT];
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_SYNC_WORD <= 32'h0000_0000;
        end else begin
            O_SYNC_WORD <= sync_word;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_OOK_CFG <= 8'h00;
        end else begin
            O_OOK_CFG <= ook_q;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_TX_CFG <= 8'h00;
        end else begin
            O_TX_CFG <= tx_q;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PAYLOAD_CFG <= 8'h00;
        end else begin
            O_PAYLOAD_CFG <= pay_q;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_NODE_ADDR <= 8'h00;
        end else begin
            O_NODE_ADDR <= node_q;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PKT_CFG <= 8'h00;
        end else begin
            O_PKT_CFG <= pkt_view;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_FIFO_CRC_CFG <= 8'h00;
        end else begin
            O_FIFO_CRC_CFG <= fcrc_q;
        end
    end
endmodule // trcfg_top
`default_nettype wire

// *** testbench/test_trcfg_top.sv ***
`default_nettype none
module test_trcfg_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  rw_idx [9] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1C, 8'h1D, 8'h1F};
    logic        clk, rst_n, psel, penable, pwrite, crc_ok, pready, pslverr, rsvd, pll, er;
    logic [31:0] paddr, pwdata, prdata, sync_w, rd;
    logic [7:0]  rssi, ook, txc, pay, node, pkt, fcrc;
    logic [4:0]  mode;
    logic [1:0]  band, vco;
    logic [3:0]  strb;
    int          err_count;
    int          checked;
    trcfg_top DUT (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(strb),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RSSI(rssi),
        .I_CRC_OK(crc_ok), .O_CHIP_MODE(mode), .O_MODE_RESERVED(rsvd), .O_BAND_SELECT(band),
        .O_VCO_TUNE_TRIM(vco), .O_PLL_DIVIDER_SET_SELECT(pll), .O_SYNC_WORD(sync_w),
        .O_OOK_CFG(ook), .O_TX_CFG(txc), .O_PAYLOAD_CFG(pay), .O_NODE_ADDR(node),
        .O_PKT_CFG(pkt), .O_FIFO_CRC_CFG(fcrc));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Holds the request until ready is sampled; a lost ready is cut off by the count
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= {22'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) err_count++;
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'h0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic do_reset();
        rst_n <= 1'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        settle();
    endtask
    task automatic close_out();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        close_out();
    end
    initial begin
        {rst_n, psel, penable, pwrite, crc_ok, paddr, pwdata} = '0;
        err_count = 0;
        checked = 0;
        rssi = 8'h5A;
        strb = 4'hF;
        do_reset();
        rdchk(8'h00, 8'h28);
        chk({27'h0, mode}, 32'h2);
        chk({27'h0, band, vco, pll}, 32'h8);
        $display("done: reset values");
        for (int i = 0; i < 9; i++) begin
            xfer(1'h1, rw_idx[i], rw_idx[i] ^ 8'hA5);
            rdchk(rw_idx[i], rw_idx[i] ^ 8'hA5);
        end
        settle();
        chk(sync_w, 32'hB3B2BDBC);
        chk({ook, txc, pay, node}, 32'hB0BFB9B8);
        chk({24'h0, fcrc}, 32'hBA);
        @(posedge clk);
        strb <= 4'hE;
        xfer(1'h1, 8'h1D, 8'h55);
        strb <= 4'hF;
        chk({31'h0, er}, 32'h0);
        rdchk(8'h1D, 8'hB8);
        $display("done: config registers");
        rdchk(8'h14, 8'h5A);
        xfer(1'h1, 8'h14, 8'hFF);
        chk({31'h0, er}, 32'h0);
        rssi <= 8'hC3;
        rdchk(8'h14, 8'hC3);
        $display("done: strength readout");
        xfer(1'h1, 8'h1E, 8'hFF);
        rdchk(8'h1E, 8'hFE);
        crc_ok <= 1'h1;
        settle();
        rdchk(8'h1E, 8'hFF);
        chk({24'h0, pkt}, 32'hFF);
        $display("done: packet status");
        for (int i = 0; i < 3; i++) begin
            xfer(1'h1, 8'h00, {3'(i + 2), 2'h1, 3'(i + 5)});
            settle();
            chk({27'h0, mode}, 32'h4 << i);
            chk({29'h0, vco, pll}, 32'(i + 5));
        end
        for (int i = 0; i < 2; i++) begin
            xfer(1'h1, 8'h00, 8'hC0 - 8'(i * 32));
            settle();
            chk({26'h0, rsvd, mode}, 32'h30);
        end
        xfer(1'h1, 8'h00, 8'h08);
        settle();
        chk({26'h0, rsvd, mode}, 32'h01);
        $display("done: chip modes");
        for (int i = 0; i < 3; i++) begin
            xfer(1'h1, 8'h1B - 8'(i * 13), 8'hFF);
            chk({31'h0, er}, 32'h1);
            rdchk(8'h1B - 8'(i * 13), 8'h00);
        end
        $display("done: unmapped");
        do_reset();
        rdchk(8'h00, 8'h28);
        chk({27'h0, mode}, 32'h2);
        $display("done: second reset");
        close_out();
    end
endmodule // test_trcfg_top
bind trcfg_top trcfg_checker u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB), .I_RSSI(I_RSSI), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_CHIP_MODE(O_CHIP_MODE),
    .O_MODE_RESERVED(O_MODE_RESERVED), .O_VCO_TUNE_TRIM(O_VCO_TUNE_TRIM),
    .O_PLL_DIVIDER_SET_SELECT(O_PLL_DIVIDER_SET_SELECT), .O_SYNC_WORD(O_SYNC_WORD));
`default_nettype wire

// *** testbench/trcfg_checker.sv ***
`default_nettype none
module trcfg_checker (
    input wire logic        I_CORE_CLK,
    input wire logic        I_RESET_N,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [31:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0]  I_PSTRB,
    input wire logic [7:0]  I_RSSI,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic [4:0]  O_CHIP_MODE,
    input wire logic        O_MODE_RESERVED,
    input wire logic [1:0]  O_VCO_TUNE_TRIM,
    input wire logic        O_PLL_DIVIDER_SET_SELECT,
    input wire logic [31:0] O_SYNC_WORD
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    logic       done;
    logic       wr;
    logic [7:0] idx;
    assign done = I_PSEL & I_PENABLE & O_PREADY;
    assign wr   = done & I_PWRITE & I_PSTRB[0];
    assign idx  = I_PADDR[9:2];
    a_ready_wait: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
        else $error("ready not given one cycle into the access phase");
    a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held longer than one cycle");
    a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error seen without ready");
    a_hole_refused: assert property (done && idx == 8'h1B |-> O_PSLVERR)
        else $error("unmapped location answered without error");
    a_rssi_readout: assert property (done && !I_PWRITE && idx == 8'h14
        |-> O_PRDATA == {24'h0, $past(I_RSSI, 2)}) else $error("strength read wrong");
    a_sync_first: assert property (wr && idx == 8'h16
        |-> ##2 O_SYNC_WORD[31:24] == $past(I_PWDATA[7:0], 2)) else $error("sync top byte");
    a_sync_last: assert property (wr && idx == 8'h19
        |-> ##2 O_SYNC_WORD[7:0] == $past(I_PWDATA[7:0], 2)) else $error("sync low byte");
    a_gen_trim: assert property (wr && idx == 8'h00
        |-> ##2 {O_VCO_TUNE_TRIM, O_PLL_DIVIDER_SET_SELECT} == $past(I_PWDATA[2:0], 2))
        else $error("trim or divider select not following write");
    a_mode_hold: assert property (O_MODE_RESERVED |-> $stable(O_CHIP_MODE))
        else $error("mode moved on a reserved code");
    a_mode_onehot: assert property ($onehot(O_CHIP_MODE))
        else $error("mode output not one-hot");
endmodule // trcfg_checker
`default_nettype wire
